// [verilog/wpm_pkg.sv]
// Package for the wireless power-save and peripheral module-disable block
package wpm_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_DISABLE_1   = 4'h0;
  localparam logic [3:0] ADDR_DISABLE_2   = 4'h1;
  localparam logic [3:0] ADDR_DISABLE_3   = 4'h2;
  localparam logic [3:0] ADDR_PWR_CTRL    = 4'h3;
  localparam logic [3:0] ADDR_SLEEP_TIME  = 4'h4;
  localparam logic [3:0] ADDR_WAKE_TIME   = 4'h5;
  localparam logic [3:0] ADDR_PWR_STATUS  = 4'h6;
  localparam logic [3:0] ADDR_LOCK        = 4'h7;

  // Implemented-bit masks of the disable registers
  localparam logic [31:0] DISABLE_1_MASK  = 32'h2589_8991;
  localparam logic [31:0] DISABLE_2_MASK  = 32'hf07f_0f0f;
  localparam logic [31:0] DISABLE_3_MASK  = 32'h1903_1317;
  localparam logic [31:0] DISABLE_RESET   = 32'h0000_0000;

  // Power control register fields
  localparam int CTRL_LIGHT_REQ_BIT       = 0;
  localparam int CTRL_DEEP_REQ_BIT        = 1;
  localparam int CTRL_EXIT_BIT            = 2;
  localparam int CTRL_REG_OFF_BIT         = 30;
  localparam logic [31:0] PWR_CTRL_RESET  = 32'h0000_0000;

  // Default sleep and run dwell counts, in clock cycles
  localparam logic [31:0] SLEEP_TIME_RESET = 32'h0000_0400;
  localparam logic [31:0] WAKE_TIME_RESET  = 32'h0000_0040;

  // Per-domain radio power and clock controls
  typedef struct packed {
    logic osc_on;     // Primary oscillator running
    logic pwr_on;     // Subsystem supply present
    logic reg_clk_on; // Regulator clocks
    logic pll_clk_on; // PLL clock
    logic trx_clk_on; // Transmit and receive chain clocks
    logic retain;     // RAM and register retention active
  } wpm_radio_s;

  // Sleep controller states
  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_LIGHT = 5'b00010,
    ST_DEEP  = 5'b00100,
    ST_WAKE  = 5'b01000,
    ST_OFF   = 5'b10000
  } wpm_state_e;

endpackage

// [verilog/wpm_power_ctrl.sv]
// Wireless sleep controller and peripheral module-disable register bank
//
// What this block does
// RULE_01: Light sleep entered independently of the processor sleep state.
// RULE_02: Light sleep keeps oscillator on; gates regulator, PLL, radio chain clocks.
// RULE_03: Light and deep sleep keep RAM and radio registers retained.
// RULE_04: Wake releases processor hold so it resumes at next instruction.
// RULE_05: Light sleep ends on timer done, access point data, or processor exit.
// RULE_06: Deep sleep powers down oscillator, regulators, PLL and radio chains.
// RULE_07: Other oscillator users turn a deep sleep request into light sleep.
// RULE_08: Deep sleep entered without putting the whole system to sleep.
// RULE_09: Deep sleep ends on the same three wake events.
// RULE_10: Power-off removes all subsystem power, losing its registers and memory.
// RULE_11: Regulator-off bit 30 of power control enters power-off.
// RULE_12: No hardware wake from power-off; software re-initialises.
// RULE_13: Software saves needed state to retention memory before power-off.
// RULE_14: Disable bit one disables, zero enables; all reset to zero.
// RULE_15: Implemented disable bits are readable, writable and lockable.
// RULE_16: Unimplemented disable positions ignore writes and read zero.
// RULE_17: First register upper half: quad serial, RNG, crypto, DMA, RTC.
// RULE_18: First register lower half: sensing, pattern, converters, voltage detector.
// RULE_19: Voltage detector and converter core bits disable those cores.
// RULE_20: Second register: reference clocks, timers, output compares, input captures.
// RULE_21: Third register: CAN, USB, I2C, wireless, SPI, Ethernet, UARTs.
// RULE_22: Sleep controller cycles run and sleep automatically, dwell times programmable.
// RULE_23: Processor sleep forces radio sleep; radio wake forces processor awake.
// RULE_24: While the lock is set, disable-bit writes are ignored.
// RULE_25: Disable outputs follow the register from the cycle after the write.
module wpm_power_ctrl (
  input  wire logic                    i_mclk,          // System clock, 100 MHz
  input  wire logic                    i_rst_n,         // Synchronous reset, active low
  input  wire logic [3:0]              i_addr,          // Register index
  input  wire logic [31:0]             i_wdata,         // Write data
  input  wire logic                    i_wr,            // Write strobe
  input  wire logic                    i_rd,            // Read strobe
  output logic      [31:0]             o_rdata,         // Read data, cycle after strobe
  input  wire logic                    i_cfg_lock,      // System configuration lock
  input  wire logic                    i_ap_data_pend,  // Access point signals data (pin)
  input  wire logic                    i_osc_other_req, // Other oscillator users (pin)
  input  wire logic                    i_cpu_sleep,     // Processor in its sleep state
  output logic                         o_cpu_wake,      // Pulse forcing processor awake
  output wpm_pkg::wpm_radio_s          o_radio,         // Radio power and clock controls
  output logic      [31:0]             o_disable_1,     // First peripheral disable group
  output logic      [31:0]             o_disable_2,     // Second peripheral disable group
  output logic      [31:0]             o_disable_3      // Third peripheral disable group
);
  import wpm_pkg::*;

  // Register storage
  logic [31:0] dis1_reg;
  logic [31:0] dis1_next;
  logic [31:0] dis2_reg;
  logic [31:0] dis2_next;
  logic [31:0] dis3_reg;
  logic [31:0] dis3_next;
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [31:0] sleep_time_reg;
  logic [31:0] sleep_time_next;
  logic [31:0] wake_time_reg;
  logic [31:0] wake_time_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        wake_reg;
  logic        wake_next;
  wpm_state_e  state_reg;
  wpm_state_e  state_next;

  // Pin synchronisers, two stages each
  logic [1:0]  ap_sync_reg;
  logic [1:0]  osc_sync_reg;
  wire         ap_pend   = ap_sync_reg[1];
  wire         osc_other = osc_sync_reg[1];

  // Masked write of a lockable disable register
  function automatic logic [31:0] lock_wr(input logic [31:0] cur, input logic [31:0] wd,
                                          input logic [31:0] msk, input logic hit,
                                          input logic lk);
    lock_wr = (hit && !lk) ? (wd & msk) : cur; // RULE_15 RULE_16 RULE_24
  endfunction

  // Register map: 0..2 disable groups, 3 power control, 4 sleep dwell,
  // 5 run dwell, 6 state read-back, 7 lock read-back; others read zero.
  // Power control bits: 0 light request, 1 deep request, 2 exit, 30 off.
  // Status and lock indices are read-only, so writes there are dropped.
  // Write decode
  wire wr_dis1  = i_wr && (i_addr == ADDR_DISABLE_1);
  wire wr_dis2  = i_wr && (i_addr == ADDR_DISABLE_2);
  wire wr_dis3  = i_wr && (i_addr == ADDR_DISABLE_3);
  wire wr_ctrl  = i_wr && (i_addr == ADDR_PWR_CTRL);
  wire wr_sleep = i_wr && (i_addr == ADDR_SLEEP_TIME);
  wire wr_wake  = i_wr && (i_addr == ADDR_WAKE_TIME);

  assign dis1_next = lock_wr(dis1_reg, i_wdata, DISABLE_1_MASK, wr_dis1, i_cfg_lock); // RULE_17 RULE_18
  assign dis2_next = lock_wr(dis2_reg, i_wdata, DISABLE_2_MASK, wr_dis2, i_cfg_lock); // RULE_20
  assign dis3_next = lock_wr(dis3_reg, i_wdata, DISABLE_3_MASK, wr_dis3, i_cfg_lock); // RULE_21

  // Dwell times are software programmable
  assign sleep_time_next = wr_sleep ? i_wdata : sleep_time_reg; // RULE_22
  assign wake_time_next  = wr_wake  ? i_wdata : wake_time_reg;  // RULE_22

  // Control bits
  wire light_req = ctrl_reg[CTRL_LIGHT_REQ_BIT];
  wire deep_req  = ctrl_reg[CTRL_DEEP_REQ_BIT];
  wire exit_req  = ctrl_reg[CTRL_EXIT_BIT];
  wire reg_off   = ctrl_reg[CTRL_REG_OFF_BIT];

  // Exit is a self-clearing request, taken in any light or deep sleep cycle that sees it
  wire exit_taken = exit_req && (state_reg == ST_LIGHT || state_reg == ST_DEEP);
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = i_wdata;
    end
    if (exit_taken && !(wr_ctrl && i_wdata[CTRL_EXIT_BIT])) begin
      ctrl_next[CTRL_EXIT_BIT] = 1'b0;
    end
  end

  // Sleep is asked by software or forced by processor sleep
  wire sleep_ask   = light_req || deep_req || i_cpu_sleep; // RULE_01 RULE_08 RULE_23
  wire go_deep     = deep_req && !osc_other;               // RULE_07
  wire timer_done  = (cnt_reg == 32'h0000_0000);
  wire wake_event  = timer_done || ap_pend || exit_req;     // RULE_05 RULE_09

  // Sleep controller: run, sleep, wake cycle with dwell counters
  always_comb begin
    state_next = state_reg;
    cnt_next   = (cnt_reg != 32'h0000_0000) ? cnt_reg - 32'h0000_0001 : cnt_reg;
    wake_next  = 1'b0;
    unique case (state_reg)
      // Run: sleep again only once the run dwell has drained
      ST_RUN: begin
        if (reg_off) begin
          state_next = ST_OFF; // RULE_11
        end else if (sleep_ask && timer_done) begin
          state_next = go_deep ? ST_DEEP : ST_LIGHT; // RULE_07
          cnt_next   = sleep_time_reg;
        end
      end
      // Asleep: power-off and oscillator demand outrank wake events
      ST_LIGHT, ST_DEEP: begin
        if (reg_off) begin
          state_next = ST_OFF; // RULE_11
        end else if (state_reg == ST_DEEP && osc_other) begin
          state_next = ST_LIGHT; // RULE_07
        end else if (wake_event && !(i_cpu_sleep && timer_done && !exit_req && !ap_pend)) begin
          state_next = ST_WAKE; // RULE_05 RULE_09
          wake_next  = 1'b1;    // RULE_04 RULE_23
        end
      end
      // One-cycle wake step that pulses the processor out of sleep
      ST_WAKE: begin
        state_next = ST_RUN;
        cnt_next   = wake_time_reg; // RULE_22
      end
      // Power-off: only software clearing the regulator bit leaves it
      ST_OFF: begin
        if (!reg_off) begin
          state_next = ST_RUN; // RULE_12
          cnt_next   = 32'h0000_0000;
        end
      end
      // Illegal code: recover to run rather than hang
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // Radio power and clock controls by state
  always_comb begin
    o_radio = '{osc_on: 1'b1, pwr_on: 1'b1, reg_clk_on: 1'b1,
                pll_clk_on: 1'b1, trx_clk_on: 1'b1, retain: 1'b0};
    unique case (state_reg)
      ST_LIGHT: o_radio = '{osc_on: 1'b1, pwr_on: 1'b1, reg_clk_on: 1'b0,
                            pll_clk_on: 1'b0, trx_clk_on: 1'b0, retain: 1'b1}; // RULE_02 RULE_03
      ST_DEEP:  o_radio = '{osc_on: 1'b0, pwr_on: 1'b1, reg_clk_on: 1'b0,
                            pll_clk_on: 1'b0, trx_clk_on: 1'b0, retain: 1'b1}; // RULE_06 RULE_03
      ST_OFF:   o_radio = '{osc_on: 1'b0, pwr_on: 1'b0, reg_clk_on: 1'b0,
                            pll_clk_on: 1'b0, trx_clk_on: 1'b0, retain: 1'b0}; // RULE_10
      default:  o_radio = '{osc_on: 1'b1, pwr_on: 1'b1, reg_clk_on: 1'b1,
                            pll_clk_on: 1'b1, trx_clk_on: 1'b1, retain: 1'b0};
    endcase
  end

  // Read mux; unmapped indices read zero
  wire [31:0] status_word = {27'h0, state_reg};
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_DISABLE_1:  rdata_next = dis1_reg; // RULE_15
        ADDR_DISABLE_2:  rdata_next = dis2_reg;
        ADDR_DISABLE_3:  rdata_next = dis3_reg;
        ADDR_PWR_CTRL:   rdata_next = ctrl_reg;
        ADDR_SLEEP_TIME: rdata_next = sleep_time_reg;
        ADDR_WAKE_TIME:  rdata_next = wake_time_reg;
        ADDR_PWR_STATUS: rdata_next = status_word;
        ADDR_LOCK:       rdata_next = {31'h0, i_cfg_lock};
        default:         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // First disable group, reset to enabled
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dis1_reg <= DISABLE_RESET; // RULE_14
    end else begin
      dis1_reg <= dis1_next;
    end
  end

  // Second disable group, reset to enabled
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dis2_reg <= DISABLE_RESET; // RULE_14
    end else begin
      dis2_reg <= dis2_next;
    end
  end

  // Third disable group, reset to enabled
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      dis3_reg <= DISABLE_RESET; // RULE_14
    end else begin
      dis3_reg <= dis3_next;
    end
  end

  // Power control word
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl_reg <= PWR_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Sleep dwell
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sleep_time_reg <= SLEEP_TIME_RESET;
    end else begin
      sleep_time_reg <= sleep_time_next;
    end
  end

  // Run dwell
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wake_time_reg <= WAKE_TIME_RESET;
    end else begin
      wake_time_reg <= wake_time_next;
    end
  end

  // Read data stands one cycle, zero otherwise
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Controller state
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Dwell counter starts at zero, so the first sleep request needs no run dwell
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_reg <= 32'h0000_0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Registered wake pulse, so the processor never sees a glitch
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_next;
    end
  end

  // Data pending pin is asynchronous, so two stages before any use
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ap_sync_reg <= 2'b00;
    end else begin
      ap_sync_reg <= {ap_sync_reg[0], i_ap_data_pend};
    end
  end

  // Oscillator demand pin, synchronised the same way
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      osc_sync_reg <= 2'b00;
    end else begin
      osc_sync_reg <= {osc_sync_reg[0], i_osc_other_req};
    end
  end

  // Disable outputs come straight from the registers
  assign o_disable_1 = dis1_reg; // RULE_19 RULE_25
  assign o_disable_2 = dis2_reg; // RULE_25
  assign o_disable_3 = dis3_reg; // RULE_25
  assign o_rdata     = rdata_reg;
  assign o_cpu_wake  = wake_reg; // RULE_23

  // Limitations a user must know:
  // - Power-off has no hardware wake. Software clears the regulator bit
  //   and must bring the radio up again from scratch; the controller
  //   restarts in run with an empty dwell counter.
  // - Anything the radio needs after power-off has to be saved to the
  //   retention memory first; this block does not do that by itself.
  // - The exit bit clears itself in any light or deep sleep cycle that sees it. A write
  //   that sets it again in that same cycle wins over the clear.
  // - An exit written while running waits and ends the next sleep at once.
  // - Holding the processor asleep suppresses the timer wake only; data
  //   pending and an exit request still wake the radio.
  // - A deep sleep request falls back to light sleep while any other user
  //   holds the oscillator, and drops to light sleep if one appears.
  // - The lock guards the disable groups only; dwell and control words
  //   stay writable so power saving keeps working in a locked system.
  // - Pins are seen two cycles late through their synchronisers, which
  //   trades a little wake latency for freedom from metastability.
  // - Dwell times count system clocks; zero sleep dwell wakes at once.

endmodule

// [verification/wpm_power_ctrl_assertions.sv]
// Port checks for the wireless power and module-disable block
module wpm_power_ctrl_assertions (
  input wire logic               i_mclk,          // Clock
  input wire logic               i_rst_n,         // Reset, active low
  input wire logic [3:0]         i_addr,          // Register index
  input wire logic [31:0]        i_wdata,         // Write data
  input wire logic               i_wr,            // Write strobe
  input wire logic               i_rd,            // Read strobe
  input wire logic [31:0]        o_rdata,         // Read data
  input wire logic               i_cfg_lock,      // Lock
  input wire logic               i_ap_data_pend,  // Data pending pin
  input wire logic               i_osc_other_req, // Other oscillator users
  input wire logic               o_cpu_wake,      // Wake pulse
  input wire wpm_pkg::wpm_radio_s o_radio,        // Radio controls
  input wire logic [31:0]        o_disable_1,     // Group 1
  input wire logic [31:0]        o_disable_2,     // Group 2
  input wire logic [31:0]        o_disable_3      // Group 3
);
  import wpm_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Implemented positions, built from the bit lists, not the package
  localparam logic [31:0] M1 = 32'h2589_8991;
  localparam logic [31:0] M2 = 32'hf07f_0f0f;
  localparam logic [31:0] M3 = 32'h1903_1317;
  // Radio asleep: powered but chains stopped
  wire sl = o_radio.pwr_on & ~o_radio.trx_clk_on;

  property p_rst; $rose(i_rst_n) |-> (o_disable_1 | o_disable_2 | o_disable_3) == 32'h0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("disable bits not clear after reset");
  property p_unimp; ((o_disable_1 & ~M1) | (o_disable_2 & ~M2) | (o_disable_3 & ~M3)) == 32'h0;
  endproperty
  a_unimp: assert property (p_unimp)
    else $error("unimplemented disable bit set");
  property p_wr; i_wr && !i_cfg_lock && i_addr == ADDR_DISABLE_1
    |=> o_disable_1 == ($past(i_wdata) & M1); endproperty
  a_wr: assert property (p_wr)
    else $error("group 1 did not follow write");
  property p_lock; i_wr && i_cfg_lock |=> $stable({o_disable_1, o_disable_2, o_disable_3});
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked disable bits changed");
  property p_rd; i_rd && i_addr == ADDR_DISABLE_2 |=> o_rdata == $past(o_disable_2); endproperty
  a_rd: assert property (p_rd)
    else $error("group 2 read back wrong");
  property p_light; o_radio.osc_on && !o_radio.trx_clk_on |-> o_radio == 6'b110001; endproperty
  a_light: assert property (p_light)
    else $error("light sleep controls wrong");
  property p_deep; o_radio.pwr_on && !o_radio.osc_on |-> o_radio == 6'b010001; endproperty
  a_deep: assert property (p_deep)
    else $error("deep sleep controls wrong");
  property p_off; !o_radio.pwr_on |-> o_radio == 6'b000000; endproperty
  a_off: assert property (p_off)
    else $error("power-off left something on");
  property p_wake; o_cpu_wake |-> !$past(o_radio.trx_clk_on) ##1 !o_cpu_wake; endproperty
  a_wake: assert property (p_wake)
    else $error("wake pulse not a single leave-sleep cycle");
  property p_ap; (sl && i_ap_data_pend) [*3] |-> ##[0:2] o_cpu_wake; endproperty
  a_ap: assert property (p_ap)
    else $error("pending data did not wake radio");
  property p_osc; i_osc_other_req [*4] |-> o_radio.osc_on || !o_radio.pwr_on; endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator stopped while still requested");
  c_wake: cover property (o_cpu_wake);
  c_deep: cover property (sl && !o_radio.osc_on);
  c_off: cover property (!o_radio.pwr_on);
endmodule

bind wpm_power_ctrl wpm_power_ctrl_assertions u_chk (.i_mclk, .i_rst_n, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_cfg_lock, .i_ap_data_pend, .i_osc_other_req, .o_cpu_wake,
  .o_radio, .o_disable_1, .o_disable_2, .o_disable_3);

// [verification/wpm_far_model.sv]
// Far side: access point with pending data and other oscillator users
module wpm_far_model (
  input  wire logic                i_mclk,     // Clock
  input  wire wpm_pkg::wpm_radio_s i_radio,    // Radio controls
  input  wire logic                i_pend_cmd, // Bench raises pending data
  input  wire logic                i_osc_cmd,  // Bench claims the oscillator
  output logic                     o_ap_pend,  // Data pending pin
  output logic                     o_osc_req   // Other oscillator users
);
  import wpm_pkg::*;
  logic armed;
  initial armed = 1'b0;
  // Data stays pending until the radio runs again, like a real access point
  always @(posedge i_mclk) begin
    if (i_pend_cmd) begin
      armed <= 1'b1;
    end else if (i_radio.trx_clk_on) begin
      armed <= 1'b0;
    end
  end
  assign o_ap_pend = armed & ~i_radio.trx_clk_on;
  assign o_osc_req = i_osc_cmd;
endmodule

// [verification/wpm_power_ctrl_tb_top.sv]
// Self-checking bench for the wireless power and module-disable block
module wpm_power_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import wpm_pkg::*;
  logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_cfg_lock = 1'b0, i_cpu_sleep = 1'b0, pend_cmd = 1'b0, osc_cmd = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, o_disable_1, o_disable_2, o_disable_3, rv, d;
  logic        ap_pend, osc_req, o_cpu_wake;
  wpm_radio_s  o_radio;
  logic [31:0] mask [3] = '{32'h2589_8991, 32'hf07f_0f0f, 32'h1903_1317};
  logic [31:0] mdl [3] = '{default: 32'h0};
  int          bad_count = 0, n_checks = 0, k, a2;

  always #5 i_mclk = ~i_mclk;
  wpm_power_ctrl u_dut (.i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_cfg_lock, .i_ap_data_pend(ap_pend), .i_osc_other_req(osc_req), .i_cpu_sleep,
    .o_cpu_wake, .o_radio, .o_disable_1, .o_disable_2, .o_disable_3);
  wpm_far_model u_far (.i_mclk, .i_radio(o_radio), .i_pend_cmd(pend_cmd), .i_osc_cmd(osc_cmd),
    .o_ap_pend(ap_pend), .o_osc_req(osc_req));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus cycles end at a falling edge so checks see settled values
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(negedge i_mclk);
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    rv = o_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  // Bounded wait for the wake pulse
  task automatic wake(input int n);
    k = 0;
    while (o_cpu_wake !== 1'b1 && k < n) begin
      @(negedge i_mclk);
      k++;
    end
    chk({31'h0, o_cpu_wake}, 32'h1);
  endtask
  task automatic dis_chk;
    chk(o_disable_1, mdl[0]);
    chk(o_disable_2, mdl[1]);
    chk(o_disable_3, mdl[2]);
  endtask
  // Expected radio controls: 0 run, 1 light, 2 deep, 3 off
  function automatic logic [31:0] rad(input int s);
    case (s)
      1: return 32'h31;
      2: return 32'h11;
      3: return 32'h0;
      default: return 32'h3e;
    endcase
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #100us;
    bad_count++;
    $display("BAD %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    k = $urandom(35);
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    dis_chk();
    rd(ADDR_SLEEP_TIME);
    chk(rv, 32'h400);
    // Full-ones corners first, then random words
    for (int i = 0; i < 24; i++) begin
      a2 = (i < 3) ? i : $urandom % 3;
      d = (i < 3) ? 32'hffff_ffff : $urandom;
      wr(a2[3:0], d);
      mdl[a2] = d & mask[a2];
      dis_chk();
      rd(a2[3:0]);
      chk(rv, mdl[a2]);
    end
    i_cfg_lock <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(i[3:0], ~mdl[i]);
      dis_chk();
    end
    rd(ADDR_LOCK);
    chk(rv, 32'h1);
    i_cfg_lock <= 1'b0;
    wr(4'hc, 32'hffff_ffff);
    rd(4'hc);
    chk(rv, 32'h0);
    $display("test registers done");
    wr(ADDR_WAKE_TIME, 32'h0000_000a);
    wr(ADDR_SLEEP_TIME, 32'h0000_001e);
    wr(ADDR_PWR_CTRL, 32'h1);
    cyc(3);
    chk({26'h0, o_radio}, rad(1));
    wake(40);
    cyc(16);
    chk({26'h0, o_radio}, rad(1));
    wr(ADDR_PWR_CTRL, 32'h5);
    wake(6);
    wr(ADDR_PWR_CTRL, 32'h0);
    $display("test light sleep done");
    wr(ADDR_PWR_CTRL, 32'h2);
    cyc(12); // Run dwell of ten cycles drains first
    chk({26'h0, o_radio}, rad(2));
    pend_cmd <= 1'b1;
    cyc(1);
    pend_cmd <= 1'b0;
    wake(8);
    wr(ADDR_PWR_CTRL, 32'h0);
    osc_cmd <= 1'b1;
    wr(ADDR_PWR_CTRL, 32'h2);
    cyc(12); // Run dwell of ten cycles drains first
    chk({26'h0, o_radio}, rad(1));
    wr(ADDR_PWR_CTRL, 32'h4);
    wake(6);
    osc_cmd <= 1'b0;
    $display("test deep sleep done");
    i_cpu_sleep <= 1'b1;
    cyc(40);
    chk({26'h0, o_radio}, rad(1));
    wr(ADDR_PWR_CTRL, 32'h4);
    wake(6);
    i_cpu_sleep <= 1'b0;
    $display("test processor sleep done");
    wr(ADDR_PWR_CTRL, 32'h4000_0000);
    cyc(2);
    chk({26'h0, o_radio}, rad(3));
    rd(ADDR_PWR_STATUS);
    chk(rv, 32'h10);
    cyc(1);
    chk(o_rdata, 32'h0);
    wr(ADDR_PWR_CTRL, 32'h0);
    cyc(2);
    chk({26'h0, o_radio}, rad(0));
    dis_chk();
    $display("test power-off done");
    final_report();
  end
endmodule
